// ---- flash_ctrl_pkg.sv ----
// Constants, register map and types for the LED drive override controller
package flash_ctrl_pkg;
    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int CLK_HZ = 50_000_000;
    localparam int DEGLITCH_US = 250;
    localparam int DEGLITCH_CYC = (CLK_HZ / 1_000_000) * DEGLITCH_US;
    // ------------------------------------------------------------
    // Register indices (byte address is four times the index)
    // ------------------------------------------------------------
    localparam int ADDR_W = 10;
    localparam logic [7:0] IDX_STATUS = 8'h04;
    localparam logic [7:0] IDX_ENABLE = 8'h10;
    localparam logic [7:0] IDX_INDIC = 8'h12;
    localparam logic [7:0] IDX_GPIO = 8'h20;
    localparam logic [7:0] IDX_VINMON = 8'h80;
    localparam logic [7:0] IDX_FLAGS = 8'hD0;
    localparam logic [7:0] IDX_CFG1 = 8'hE0;
    localparam logic [7:0] IDX_CFG2 = 8'hF0;
    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [7:0] RST_ENABLE = 8'hF8;
    localparam logic [7:0] RST_INDIC = 8'hF8;
    localparam logic [7:0] RST_GPIO = 8'h80;
    localparam logic [7:0] RST_VINMON = 8'hF8;
    localparam logic [7:0] RST_FLAGS = 8'h00;
    localparam logic [7:0] RST_CFG1 = 8'h6A;
    localparam logic [7:0] RST_CFG2 = 8'hF0;
    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int EN_STR = 2;
    localparam int C1_NTCMODE = 4;
    localparam int C1_TX1POL = 5;
    localparam int C1_TX2POL = 6;
    localparam int C1_HWTORCH = 7;
    localparam int C2_TX2SHUT = 0;
    localparam int C2_NTCOFF = 1;
    localparam int C2_AET = 2;
    localparam int C2_VINOFF = 3;
    localparam int GP_G1EN = 0;
    localparam int GP_G1DIR = 1;
    localparam int GP_G1OUT = 2;
    localparam int GP_G2EN = 3;
    localparam int GP_G2DIR = 4;
    localparam int GP_G2OUT = 5;
    localparam int GP_INTEN = 6;
    localparam int VM_EN = 0;
    localparam int FL_TO = 0;
    localparam int FL_TX1 = 3;
    localparam int FL_TX2 = 4;
    localparam int FL_NTC = 5;
    localparam int FL_VIN = 7;
    localparam int ST_G1IN = 0;
    localparam int ST_G2IN = 1;
    localparam int ST_NTCF = 2;
    localparam int ST_VINF = 3;
    localparam int ST_TX2SD = 4;
    localparam int ST_FLASH = 5;
    // ------------------------------------------------------------
    // Encodings
    // ------------------------------------------------------------
    localparam logic [1:0] MODE_OFF = 2'h0;
    localparam logic [1:0] MODE_IND = 2'h1;
    localparam logic [1:0] MODE_TORCH = 2'h2;
    localparam logic [1:0] MODE_FLASH = 2'h3;
    localparam logic [1:0] LED_OFF = 2'h0;
    localparam logic [1:0] LED_TORCH = 2'h1;
    localparam logic [1:0] LED_FLASH = 2'h2;
    typedef enum logic [1:0] {
        F_IDLE = 2'h0,
        F_HOLD = 2'h3,
        F_RUN = 2'h1
    } flash_st_t;
endpackage

// ---- led_override_ctrl.sv ----
// LED drive state selection with pulse interrupts, fault overrides and register slave
`timescale 1ns/1ns
// Summary of operation
// RULE_01: Hardware torch bit clear makes the first pin a flash interrupt input.
// RULE_02: First pin active during flash forces torch; timeout ends flash anyway.
// RULE_03: First pin released before flash end returns to flash current.
// RULE_04: Polarity bit inverts the first pin; inverted means low is active.
// RULE_05: Hardware torch bit set: high on first pin turns torch on.
// RULE_06: Flash from strobe or enable bits beats hardware torch.
// RULE_07: Flash end in hardware torch mode clears that bit; LED goes off.
// RULE_08: General purpose bit 0 makes first pin a GPIO, bits 2:1 set it.
// RULE_09: Second pin active during flash forces torch, releases back to flash.
// RULE_10: Shutdown bit set: second pin event shuts the flash pulse down.
// RULE_11: Shutdown ends on flag read; pin still active gives torch instead.
// RULE_12: Second pin shutdown is edge triggered; new edge needed after read.
// RULE_13: General purpose bit 3 makes second pin a GPIO, bit 4 direction.
// RULE_14: Interrupt output mode pulls second pin low on thermistor or supply fault.
// RULE_15: Thermistor mode clear: indicator on when enable mode is 01, 8 levels.
// RULE_16: Thermistor mode set disables indicator, pin becomes comparator input.
// RULE_17: Thermistor trip forces torch, or LED off when config 2 bit 1 set.
// RULE_18: Thermistor reduction clears only after flag read with input above trip.
// RULE_19: Thermistor trip with flags clear waits 250 us deglitch first.
// RULE_20: Early trigger mode: first pin before strobe holds torch without timeout.
// RULE_21: Edge sensitive strobe disables early trigger mode.
// RULE_22: Supply monitor enable, threshold select, torch or off on undervoltage.
// RULE_23: Supply reduction clears only after supply recovers and flags are read.
// RULE_24: Reading the flag register clears every flag bit.
// RULE_25: Enable mode 11 starts a flash, 10 enables steady torch.
// RULE_26: Interrupt pin event is the edge chosen by its polarity bit.
// RULE_27: Shutdown beats torch reduction, which beats full flash current.
module led_override_ctrl #(
    parameter int DEGLITCH_CYCLES = flash_ctrl_pkg::DEGLITCH_CYC
) (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic [flash_ctrl_pkg::ADDR_W-1:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic strobePin,
    input wire logic firstPulseInterruptPin,
    output logic firstPulseInterruptPinOut,
    output logic firstPulseInterruptPinOe,
    input wire logic secondPulseInterruptPin,
    output logic secondPulseInterruptPinOut,
    output logic secondPulseInterruptPinOe,
    input wire logic thermistorBelowTrip,
    input wire logic supplyBelowThreshold,
    input wire logic flashTimeoutDone,
    output logic [1:0] ledDrive,
    output logic flashTimerRun,
    output logic flashTimerRestart,
    output logic indicatorOn,
    output logic [2:0] indicatorLevel,
    output logic supplyMonitorEnable,
    output logic [1:0] supplyMonitorThreshold,
    output logic thermistorSenseMode
);
    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    localparam int DW = $clog2(DEGLITCH_CYCLES + 1);
    localparam logic [DW-1:0] DG_MAX = DW'(DEGLITCH_CYCLES);

    function automatic logic regHit(input logic [9:0] a, input logic [7:0] idx);
        return a == {idx, 2'b00};
    endfunction

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    logic [7:0] enable_ff, indic_ff, gpio_ff, vinmon_ff, flags_ff, cfg1_ff, cfg2_ff;
    logic [7:0] nxt_enable, nxt_cfg1, nxt_flags;
    logic [4:0] meta_ff, sync_ff;
    logic strobePrev_ff, tx1ActPrev_ff, tx2ActPrev_ff;
    logic tx2Shut_ff, ntcFault_ff, vinFault_ff;
    logic [DW-1:0] deglitch_ff;
    logic [DW-1:0] nxt_deglitch;
    logic waitreq_ff;
    logic [31:0] rdata_ff;
    logic [1:0] led_ff, nxt_led;
    logic timerRun_ff, timerRestart_ff, indOn_ff;
    logic [2:0] indLevel_ff;
    logic tx1Out_ff, tx1Oe_ff, tx2Out_ff, tx2Oe_ff;
    flash_ctrl_pkg::flash_st_t state_ff, nxt_state;
    logic [7:0] rdMux, statusWord, flagSet;

    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            meta_ff <= 5'h00;
            sync_ff <= 5'h00;
        end else begin
            meta_ff <= {supplyBelowThreshold, thermistorBelowTrip,
                        secondPulseInterruptPin, firstPulseInterruptPin, strobePin};
            sync_ff <= meta_ff;
        end
    end

    wire strobeLvl = sync_ff[0];
    wire tx1Lvl = sync_ff[1];
    wire tx2Lvl = sync_ff[2];
    wire thermLvl = sync_ff[3];
    wire supplyLvl = sync_ff[4];

    // ------------------------------------------------------------
    // Bus slave: one wait cycle, then the commit edge
    // ------------------------------------------------------------
    wire busReq = avs_read | avs_write;
    wire wrCommit = avs_write & ~waitreq_ff;
    wire rdCommit = avs_read & ~waitreq_ff;
    wire wrEnable = wrCommit & regHit(avs_address, flash_ctrl_pkg::IDX_ENABLE);
    wire wrIndic = wrCommit & regHit(avs_address, flash_ctrl_pkg::IDX_INDIC);
    wire wrGpio = wrCommit & regHit(avs_address, flash_ctrl_pkg::IDX_GPIO);
    wire wrVinmon = wrCommit & regHit(avs_address, flash_ctrl_pkg::IDX_VINMON);
    wire wrCfg1 = wrCommit & regHit(avs_address, flash_ctrl_pkg::IDX_CFG1);
    wire wrCfg2 = wrCommit & regHit(avs_address, flash_ctrl_pkg::IDX_CFG2);
    wire flagsRead = rdCommit & regHit(avs_address, flash_ctrl_pkg::IDX_FLAGS);
    wire [7:0] wd = avs_writedata[7:0];

    // Unmapped addresses read as zero and ignore writes
    assign rdMux = regHit(avs_address, flash_ctrl_pkg::IDX_ENABLE) ? enable_ff :
                   regHit(avs_address, flash_ctrl_pkg::IDX_INDIC) ? indic_ff :
                   regHit(avs_address, flash_ctrl_pkg::IDX_GPIO) ? gpio_ff :
                   regHit(avs_address, flash_ctrl_pkg::IDX_VINMON) ? vinmon_ff :
                   regHit(avs_address, flash_ctrl_pkg::IDX_FLAGS) ? flags_ff :
                   regHit(avs_address, flash_ctrl_pkg::IDX_CFG1) ? cfg1_ff :
                   regHit(avs_address, flash_ctrl_pkg::IDX_CFG2) ? cfg2_ff :
                   regHit(avs_address, flash_ctrl_pkg::IDX_STATUS) ? statusWord : 8'h00;

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            waitreq_ff <= 1'b1;
            rdata_ff <= 32'h0000_0000;
        end else begin
            waitreq_ff <= ~(busReq & waitreq_ff);
            if (busReq & waitreq_ff) begin
                rdata_ff <= {24'h00_0000, rdMux};
            end
        end
    end

    // ------------------------------------------------------------
    // Pin modes and events
    // ------------------------------------------------------------
    wire gp1 = gpio_ff[flash_ctrl_pkg::GP_G1EN]; // RULE_08
    wire hwTorchMode = ~gp1 & cfg1_ff[flash_ctrl_pkg::C1_HWTORCH]; // RULE_05
    wire tx1Mode = ~gp1 & ~cfg1_ff[flash_ctrl_pkg::C1_HWTORCH]; // RULE_01
    wire tx1Act = tx1Lvl ^ cfg1_ff[flash_ctrl_pkg::C1_TX1POL]; // RULE_04
    wire tx2Mode = ~gpio_ff[flash_ctrl_pkg::GP_G2EN]; // RULE_13
    wire tx2Act = tx2Lvl ^ cfg1_ff[flash_ctrl_pkg::C1_TX2POL]; // RULE_26
    wire tx1Over = tx1Mode & tx1Act;
    wire tx2Over = tx2Mode & tx2Act;
    wire tx1Edge = tx1Over & ~tx1ActPrev_ff; // RULE_26
    wire tx2Edge = tx2Over & ~tx2ActPrev_ff; // RULE_26
    wire ntcMode = cfg1_ff[flash_ctrl_pkg::C1_NTCMODE];
    wire ledOn = led_ff != flash_ctrl_pkg::LED_OFF;

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            strobePrev_ff <= 1'b0;
            // Start as active so the reset sync level cannot fake an event
            tx1ActPrev_ff <= 1'b1;
            tx2ActPrev_ff <= 1'b1;
        end else begin
            strobePrev_ff <= strobeLvl;
            tx1ActPrev_ff <= tx1Over;
            tx2ActPrev_ff <= tx2Over;
        end
    end

    // ------------------------------------------------------------
    // Flash sequencing
    // ------------------------------------------------------------
    wire edgeMode = enable_ff[flash_ctrl_pkg::EN_STR];
    wire aetOn = cfg2_ff[flash_ctrl_pkg::C2_AET] & ~edgeMode; // RULE_21
    wire strobeRise = strobeLvl & ~strobePrev_ff;
    wire enFlash = enable_ff[1:0] == flash_ctrl_pkg::MODE_FLASH;
    wire flashWrite = wrEnable & (wd[1:0] == flash_ctrl_pkg::MODE_FLASH); // RULE_25
    wire startReq = strobeRise | flashWrite;
    // Edge sensitive strobe ends only on timeout
    wire levelStop = ~edgeMode & ~strobeLvl & ~enFlash & ~flashWrite;
    wire flashOn = state_ff != flash_ctrl_pkg::F_IDLE;

    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            flash_ctrl_pkg::F_IDLE: begin
                if (startReq) begin
                    nxt_state = (aetOn & strobeRise & tx1Over) ? flash_ctrl_pkg::F_HOLD :
                                flash_ctrl_pkg::F_RUN; // RULE_20
                end
            end
            flash_ctrl_pkg::F_HOLD: begin
                if (levelStop) begin
                    nxt_state = flash_ctrl_pkg::F_IDLE;
                end else if (~tx1Over) begin
                    nxt_state = flash_ctrl_pkg::F_RUN; // RULE_20
                end
            end
            flash_ctrl_pkg::F_RUN: begin
                if (flashTimeoutDone | levelStop) begin
                    nxt_state = flash_ctrl_pkg::F_IDLE; // RULE_02
                end
            end
            default: begin
                nxt_state = flash_ctrl_pkg::F_IDLE;
            end
        endcase
    end

    wire flashEnd = flashOn & (nxt_state == flash_ctrl_pkg::F_IDLE);
    wire nxtRun = nxt_state == flash_ctrl_pkg::F_RUN;
    wire restart = nxtRun & ((state_ff != flash_ctrl_pkg::F_RUN) | strobeRise);

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            state_ff <= flash_ctrl_pkg::F_IDLE;
        end else begin
            state_ff <= nxt_state;
        end
    end

    // ------------------------------------------------------------
    // Fault latches
    // ------------------------------------------------------------
    wire ntcActive = ntcMode & thermLvl & ledOn;
    wire dgDone = deglitch_ff == DG_MAX;
    // Deglitch only applies with the flag clear; a pending flag trips at once
    wire ntcTrip = ntcActive & (dgDone | flags_ff[flash_ctrl_pkg::FL_NTC]); // RULE_19
    wire vinTrip = vinmon_ff[flash_ctrl_pkg::VM_EN] & supplyLvl; // RULE_22
    wire tx2ShutSet = flashOn & cfg2_ff[flash_ctrl_pkg::C2_TX2SHUT] & tx2Edge; // RULE_10 RULE_12

    always_comb begin
        nxt_deglitch = deglitch_ff;
        if (~ntcActive) begin
            nxt_deglitch = '0;
        end else if (~dgDone) begin
            nxt_deglitch = deglitch_ff + DW'(1);
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            deglitch_ff <= '0;
            tx2Shut_ff <= 1'b0;
            ntcFault_ff <= 1'b0;
            vinFault_ff <= 1'b0;
        end else begin
            deglitch_ff <= nxt_deglitch;
            tx2Shut_ff <= tx2ShutSet | (tx2Shut_ff & ~flagsRead); // RULE_11
            ntcFault_ff <= ntcTrip | (ntcFault_ff & ~(flagsRead & ~thermLvl)); // RULE_18
            vinFault_ff <= vinTrip | (vinFault_ff & ~(flagsRead & ~supplyLvl)); // RULE_23
        end
    end

    // ------------------------------------------------------------
    // Registers with hardware side effects
    // ------------------------------------------------------------
    always_comb begin
        flagSet = 8'h00;
        flagSet[flash_ctrl_pkg::FL_TO] = flashTimeoutDone & (state_ff == flash_ctrl_pkg::F_RUN);
        flagSet[flash_ctrl_pkg::FL_TX1] = tx1Edge;
        flagSet[flash_ctrl_pkg::FL_TX2] = tx2Edge;
        flagSet[flash_ctrl_pkg::FL_NTC] = ntcTrip;
        flagSet[flash_ctrl_pkg::FL_VIN] = vinTrip;
        // Set wins over the read clear so no event is lost
        nxt_flags = (flagsRead ? 8'h00 : flags_ff) | flagSet; // RULE_24
        if (~flashOn & startReq & ~flagSet[flash_ctrl_pkg::FL_TO]) begin
            nxt_flags[flash_ctrl_pkg::FL_TO] = 1'b0;
        end
    end

    always_comb begin
        nxt_enable = enable_ff;
        nxt_cfg1 = cfg1_ff;
        if (wrEnable) begin
            nxt_enable = wd;
        end else if (flashEnd) begin
            nxt_enable[1:0] = flash_ctrl_pkg::MODE_OFF;
        end
        if (wrCfg1) begin
            nxt_cfg1 = wd;
        end else if (flashEnd & hwTorchMode) begin
            nxt_cfg1[flash_ctrl_pkg::C1_HWTORCH] = 1'b0; // RULE_07
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            enable_ff <= flash_ctrl_pkg::RST_ENABLE;
            cfg1_ff <= flash_ctrl_pkg::RST_CFG1;
            flags_ff <= flash_ctrl_pkg::RST_FLAGS;
        end else begin
            enable_ff <= nxt_enable;
            cfg1_ff <= nxt_cfg1;
            flags_ff <= nxt_flags;
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            indic_ff <= flash_ctrl_pkg::RST_INDIC;
            gpio_ff <= flash_ctrl_pkg::RST_GPIO;
            vinmon_ff <= flash_ctrl_pkg::RST_VINMON;
            cfg2_ff <= flash_ctrl_pkg::RST_CFG2;
        end else begin
            indic_ff <= wrIndic ? wd : indic_ff;
            gpio_ff <= wrGpio ? wd : gpio_ff;
            vinmon_ff <= wrVinmon ? wd : vinmon_ff;
            cfg2_ff <= wrCfg2 ? wd : cfg2_ff;
        end
    end

    always_comb begin
        statusWord = 8'h00;
        statusWord[flash_ctrl_pkg::ST_G1IN] = tx1Lvl;
        statusWord[flash_ctrl_pkg::ST_G2IN] = tx2Lvl;
        statusWord[flash_ctrl_pkg::ST_NTCF] = ntcFault_ff;
        statusWord[flash_ctrl_pkg::ST_VINF] = vinFault_ff;
        statusWord[flash_ctrl_pkg::ST_TX2SD] = tx2Shut_ff;
        statusWord[flash_ctrl_pkg::ST_FLASH] = flashOn;
    end

    // ------------------------------------------------------------
    // LED drive decision
    // ------------------------------------------------------------
    wire shutOff = tx2Shut_ff |
                   (ntcFault_ff & cfg2_ff[flash_ctrl_pkg::C2_NTCOFF]) | // RULE_17
                   (vinFault_ff & cfg2_ff[flash_ctrl_pkg::C2_VINOFF]); // RULE_22
    wire reduce = tx1Over | tx2Over | ntcFault_ff | vinFault_ff |
                  (state_ff == flash_ctrl_pkg::F_HOLD); // RULE_02 RULE_09 RULE_17
    wire torchReq = (enable_ff[1:0] == flash_ctrl_pkg::MODE_TORCH) | // RULE_25
                    (hwTorchMode & tx1Lvl); // RULE_05

    always_comb begin
        if (shutOff) begin
            nxt_led = flash_ctrl_pkg::LED_OFF; // RULE_27
        end else if (flashOn) begin
            // Releasing every override returns to flash within the pulse
            nxt_led = reduce ? flash_ctrl_pkg::LED_TORCH :
                      flash_ctrl_pkg::LED_FLASH; // RULE_03 RULE_06 RULE_27
        end else if (torchReq) begin
            nxt_led = flash_ctrl_pkg::LED_TORCH;
        end else begin
            nxt_led = flash_ctrl_pkg::LED_OFF;
        end
    end

    // ------------------------------------------------------------
    // Pin drivers and outputs
    // ------------------------------------------------------------
    wire g2Out = gpio_ff[flash_ctrl_pkg::GP_G2EN] & gpio_ff[flash_ctrl_pkg::GP_G2DIR];
    wire intMode = g2Out & gpio_ff[flash_ctrl_pkg::GP_INTEN];
    wire intFault = ntcActive | vinTrip;
    wire indReq = ~ntcMode & (enable_ff[1:0] == flash_ctrl_pkg::MODE_IND); // RULE_15 RULE_16

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            led_ff <= flash_ctrl_pkg::LED_OFF;
            timerRun_ff <= 1'b0;
            timerRestart_ff <= 1'b0;
            indOn_ff <= 1'b0;
            indLevel_ff <= 3'h0;
        end else begin
            led_ff <= nxt_led;
            timerRun_ff <= nxtRun; // RULE_20
            timerRestart_ff <= restart;
            indOn_ff <= indReq;
            indLevel_ff <= indic_ff[2:0]; // RULE_15
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            tx1Out_ff <= 1'b0;
            tx1Oe_ff <= 1'b0;
            tx2Out_ff <= 1'b0;
            tx2Oe_ff <= 1'b0;
        end else begin
            tx1Out_ff <= gpio_ff[flash_ctrl_pkg::GP_G1OUT]; // RULE_08
            tx1Oe_ff <= gp1 & gpio_ff[flash_ctrl_pkg::GP_G1DIR]; // RULE_08
            // Interrupt output is open drain: only ever pulls low
            tx2Out_ff <= intMode ? 1'b0 : gpio_ff[flash_ctrl_pkg::GP_G2OUT]; // RULE_14
            tx2Oe_ff <= intMode ? intFault : g2Out; // RULE_13 RULE_14
        end
    end

    assign avs_readdata = rdata_ff;
    assign avs_waitrequest = waitreq_ff;
    assign ledDrive = led_ff;
    assign flashTimerRun = timerRun_ff;
    assign flashTimerRestart = timerRestart_ff;
    assign indicatorOn = indOn_ff;
    assign indicatorLevel = indLevel_ff;
    assign supplyMonitorEnable = vinmon_ff[flash_ctrl_pkg::VM_EN];
    assign supplyMonitorThreshold = vinmon_ff[2:1]; // RULE_22
    assign thermistorSenseMode = cfg1_ff[flash_ctrl_pkg::C1_NTCMODE]; // RULE_16
    assign firstPulseInterruptPinOut = tx1Out_ff;
    assign firstPulseInterruptPinOe = tx1Oe_ff;
    assign secondPulseInterruptPinOut = tx2Out_ff;
    assign secondPulseInterruptPinOe = tx2Oe_ff;
endmodule

// ---- led_override_ctrl_assertions.sv ----
// Port-level checks for the LED override controller
`timescale 1ns/1ns
// ------------------------------------------------------------
// Checker
// ------------------------------------------------------------
module led_override_ctrl_checker (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic [flash_ctrl_pkg::ADDR_W-1:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic avs_waitrequest,
    input wire logic flashTimeoutDone,
    input wire logic [1:0] ledDrive,
    input wire logic flashTimerRun,
    input wire logic flashTimerRestart,
    input wire logic [1:0] supplyMonitorThreshold,
    input wire logic thermistorSenseMode
);
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!rst_n);
    chk_wait_once: assert property (
        (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest) else $error("no answer");
    chk_wait_ends: assert property (
        !avs_waitrequest |=> avs_waitrequest) else $error("waitrequest low too long");
    chk_timeout_off: assert property (
        flashTimerRun && flashTimeoutDone |-> ##2 ledDrive == flash_ctrl_pkg::LED_OFF)
        else $error("LED still on after timeout");
    chk_flash_timed: assert property (
        ledDrive == flash_ctrl_pkg::LED_FLASH |-> $past(flashTimerRun))
        else $error("flash untimed");
    chk_restart_run: assert property (
        flashTimerRestart |-> flashTimerRun ##1 !flashTimerRestart) else $error("bad restart");
    chk_drive_legal: assert property (
        ledDrive != 2'h3) else $error("illegal drive code");
    chk_thr_write: assert property (
        $changed(supplyMonitorThreshold) |-> $past(avs_write && !avs_waitrequest
        && avs_address == 10'h200)) else $error("threshold moved without write");
    chk_ntc_write: assert property (
        $changed(thermistorSenseMode) |-> $past(avs_write && !avs_waitrequest
        && avs_address == 10'h380)) else $error("sense mode moved without write");
endmodule
bind led_override_ctrl led_override_ctrl_checker u_led_override_ctrl_checker (.*);

// ---- flash_timer_model.sv ----
// Host-side flash timeout timer answering the controller
`timescale 1ns/1ns
// ------------------------------------------------------------
// Timer
// ------------------------------------------------------------
module flash_timer_model #(
    parameter int LEN = 40
) (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic run,
    input wire logic restart,
    output logic done
);
    int cnt;
    // Single pulse per run: count keeps going past the end
    always_ff @(posedge clock) begin
        if (!rst_n || restart || !run) begin
            cnt <= 0;
            done <= 1'b0;
        end else begin
            cnt <= cnt + 1;
            done <= (cnt == LEN - 2);
        end
    end
endmodule

// ---- led_override_ctrl_tb.sv ----
// Self-checking bench for the LED override controller
`timescale 1ns/1ns
// ------------------------------------------------------------
// Bench
// ------------------------------------------------------------
module led_override_ctrl_tb;
    logic clock = 0, rst_n = 0, avs_read = 0, avs_write = 0, avs_waitrequest, strobePin = 0;
    logic [9:0] avs_address = 10'h000;
    logic [31:0] avs_writedata = 32'h0, avs_readdata;
    logic pin1 = 1, pin2 = 1, ntcLow = 0, vinLow = 0, toDone, run, restart, indOn, vEn, ntcMode;
    logic [1:0] ledDrive, vThr;
    int mismatches = 0, total_checks = 0;
    led_override_ctrl #(.DEGLITCH_CYCLES(8)) u_led_override_ctrl (.clock(clock), .rst_n(rst_n),
        .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .strobePin(strobePin),
        .firstPulseInterruptPin(pin1), .firstPulseInterruptPinOut(),
        .firstPulseInterruptPinOe(), .secondPulseInterruptPin(pin2),
        .secondPulseInterruptPinOut(), .secondPulseInterruptPinOe(),
        .thermistorBelowTrip(ntcLow), .supplyBelowThreshold(vinLow), .flashTimeoutDone(toDone),
        .ledDrive(ledDrive), .flashTimerRun(run), .flashTimerRestart(restart),
        .indicatorOn(indOn), .indicatorLevel(), .supplyMonitorEnable(vEn),
        .supplyMonitorThreshold(vThr), .thermistorSenseMode(ntcMode));
    flash_timer_model #(.LEN(40)) u_flash_timer_model (.clock(clock), .rst_n(rst_n),
        .run(run), .restart(restart), .done(toDone));
    task close_out;
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    task chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // Request held until waitrequest is seen low; one idle edge keeps drivers apart
    task bus(input logic wr, input logic [9:0] a, input logic [7:0] d, output logic [31:0] q);
        avs_address <= a;
        avs_writedata <= {24'h0, d};
        avs_write <= wr;
        avs_read <= !wr;
        do @(posedge clock); while (avs_waitrequest !== 1'b0);
        q = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
        @(posedge clock);
    endtask
    task wr(input logic [9:0] a, input logic [7:0] d);
        logic [31:0] q;
        bus(1'b1, a, d, q);
    endtask
    task rd(input logic [9:0] a, input logic [31:0] exp);
        logic [31:0] q;
        bus(1'b0, a, 8'h00, q);
        chk(q, exp);
    endtask
    task wait_led(input logic [1:0] v);
        int n;
        n = 0;
        while (ledDrive !== v && n < 60) begin
            @(posedge clock);
            n++;
        end
        chk(32'(ledDrive), 32'(v));
    endtask
    task s_defaults;
        rd(10'h380, 32'h6A);
        rd(10'h3C0, 32'hF0);
        rd(10'h340, 32'h00);
    endtask
    task s_pin1;
        wr(10'h040, 8'hFB);
        wait_led(flash_ctrl_pkg::LED_FLASH);
        pin1 <= 1'b0;
        wait_led(flash_ctrl_pkg::LED_TORCH);
        pin1 <= 1'b1;
        wait_led(flash_ctrl_pkg::LED_FLASH);
        wait_led(flash_ctrl_pkg::LED_OFF);
        rd(10'h040, 32'hF8);
        rd(10'h340, 32'h09);
        rd(10'h340, 32'h00);
    endtask
    task s_pin2;
        wr(10'h3C0, 8'hF1);
        wr(10'h040, 8'hFB);
        wait_led(flash_ctrl_pkg::LED_FLASH);
        pin2 <= 1'b0;
        wait_led(flash_ctrl_pkg::LED_OFF);
        pin2 <= 1'b1;
        rd(10'h340, 32'h10);
        wait_led(flash_ctrl_pkg::LED_FLASH);
        wait_led(flash_ctrl_pkg::LED_OFF);
        rd(10'h340, 32'h01);
    endtask
    task s_indicator;
        wr(10'h040, 8'hF9);
        repeat (4) @(posedge clock);
        chk(32'(indOn), 32'h1);
        wr(10'h380, 8'h7A);
        repeat (4) @(posedge clock);
        chk(32'({ntcMode, indOn}), 32'h2);
        wr(10'h200, 8'h05);
        repeat (3) @(posedge clock);
        chk(32'({vEn, vThr}), 32'h6);
    endtask
    initial begin
        forever #10 clock = ~clock;
    end
    initial begin
        repeat (20000) @(posedge clock);
        mismatches++;
        close_out();
    end
    initial begin
        repeat (12) @(posedge clock);
        rst_n <= 1'b1;
        @(posedge clock);
        s_defaults();
        s_pin1();
        s_pin2();
        s_indicator();
        close_out();
    end
endmodule
